// ---- hdl/cpu_core_pkg.sv ----
// constants, opcode map and state types shared by the core decode and execute logic
package cpu_core_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [15:0] word_t;

    localparam int unsigned IRAM_DEPTH = 256;

    // special register addresses in the upper direct space, bit area base, stack steps and reset values
    localparam byte_t SFR_SP  = 8'h81;
    localparam byte_t SFR_DPL = 8'h82;
    localparam byte_t SFR_DPH = 8'h83;
    localparam byte_t SFR_PSW = 8'hD0;
    localparam byte_t SFR_ACC = 8'hE0;
    localparam byte_t BIT_AREA_BASE = 8'h20;
    localparam byte_t SP_STEP = 8'h01;
    localparam byte_t SP_PAIR = 8'h02;
    localparam byte_t SP_RESET = 8'h07;
    localparam word_t PC_RESET = 16'h0000;

    localparam int unsigned PSW_CY    = 7;
    localparam int unsigned PSW_RS_HI = 4;
    localparam int unsigned PSW_RS_LO = 3;
    localparam int unsigned PSW_P     = 0;

    // opcodes and opcode fields
    localparam byte_t OP_LONG_JUMP_OP     = 8'h02;
    localparam byte_t OP_RR       = 8'h03;
    localparam byte_t OP_LONG_CALL_OP    = 8'h12;
    localparam byte_t OP_RRC      = 8'h13;
    localparam byte_t OP_RET      = 8'h22;
    localparam byte_t OP_RL       = 8'h23;
    localparam byte_t OP_INTERRUPT_RETURN_OP     = 8'h32;
    localparam byte_t OP_RLC      = 8'h33;
    localparam byte_t OP_JZ       = 8'h60;
    localparam byte_t OP_JNZ      = 8'h70;
    localparam byte_t OP_JMP_IDX  = 8'h73;
    localparam byte_t OP_SHORT_JUMP_OP     = 8'h80;
    localparam byte_t OP_MOVC     = 8'h93;
    localparam byte_t OP_CLR_BIT  = 8'hC2;
    localparam byte_t OP_SWAP     = 8'hC4;
    localparam byte_t OP_SETB_BIT = 8'hD2;
    localparam byte_t OP_CLR_A    = 8'hE4;
    localparam byte_t OP_CPL_A    = 8'hF4;
    localparam logic [4:0] OP_ABSOLUTE_JUMP_OP_LO  = 5'h01;
    localparam logic [4:0] OP_ABSOLUTE_CALL_OP_LO = 5'h11;
    localparam logic [3:0] OP_ORL_HI  = 4'h4;
    localparam logic [3:0] OP_ANL_HI  = 4'h5;
    localparam logic [3:0] OP_XRL_HI  = 4'h6;
    localparam logic [3:0] OP_COMPARE_JUMP_NE_OP_HI = 4'hB;
    localparam logic [3:0] OP_DECREMENT_JUMP_NZ_OP_HI = 4'hD;
    localparam logic [3:0] LN_IMM = 4'h4;
    localparam logic [3:0] LN_DIR = 4'h5;
    localparam logic [2:0] LN_TO_DIR = 3'h1;
    localparam logic [2:0] LN_IND    = 3'h3;

    // byte lengths and cycle counts
    localparam logic [1:0] LEN_ONE   = 2'h1;
    localparam logic [1:0] LEN_TWO   = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [2:0] CYC_ZERO  = 3'h0;
    localparam logic [2:0] CYC_ONE   = 3'h1;
    localparam logic [2:0] CYC_TWO   = 3'h2;
    localparam logic [2:0] CYC_THREE = 3'h3;
    localparam logic [2:0] CYC_FOUR  = 3'h4;
    localparam logic [2:0] CYC_FIVE  = 3'h5;
    localparam logic [2:0] CYC_MOVC  = 3'h2;
    localparam logic [2:0] CYC_BIT   = 3'h3;

    typedef enum logic [4:0] {
        CL_NOP    = 5'b00000,
        CL_LOGIC  = 5'b00001,
        CL_ACC    = 5'b00010,
        CL_ABSOLUTE_JUMP_OP   = 5'b00011,
        CL_ABSOLUTE_CALL_OP  = 5'b00100,
        CL_LONG_JUMP_OP   = 5'b00101,
        CL_LONG_CALL_OP  = 5'b00110,
        CL_RET    = 5'b00111,
        CL_INTERRUPT_RETURN_OP   = 5'b01000,
        CL_SHORT_JUMP_OP   = 5'b01001,
        CL_JMPIDX = 5'b01010,
        CL_JZ     = 5'b01011,
        CL_JNZ    = 5'b01100,
        CL_COMPARE_JUMP_NE_OP   = 5'b01101,
        CL_DECREMENT_JUMP_NZ_OP   = 5'b01110,
        CL_MOVC   = 5'b01111,
        CL_BIT    = 5'b10000
    } op_class_t;

    typedef enum logic [3:0] {
        LF_AND  = 4'b0000,
        LF_OR   = 4'b0001,
        LF_XOR  = 4'b0010,
        LF_CLR  = 4'b0011,
        LF_CPL  = 4'b0100,
        LF_RL   = 4'b0101,
        LF_RLC  = 4'b0110,
        LF_RR   = 4'b0111,
        LF_RRC  = 4'b1000,
        LF_SWAP = 4'b1001
    } logic_func_t;

    typedef struct packed {
        op_class_t  cls;
        logic [1:0] len;
        logic [2:0] cyc;
    } dec_t;

    typedef struct packed {
        word_t      pc;
        logic [2:0] cyc;
        byte_t      op;
        byte_t      arg1;
        byte_t      arg2;
        byte_t      acc;
        byte_t      psw;
        byte_t      sp;
        word_t      data_pointer;
    } core_state_t;

    typedef struct packed {
        word_t pc;
        byte_t acc;
        byte_t psw;
        byte_t sp;
        word_t data_pointer;
    } cpu_view_t;

    localparam core_state_t CORE_RESET = '{pc: PC_RESET, sp: SP_RESET, default: '0};
endpackage : cpu_core_pkg

// ---- hdl/byte_logic_unit.sv ----
// bitwise, rotate and swap operations on one byte
`timescale 1ns/100ps
module byte_logic_unit (
    input  wire cpu_core_pkg::logic_func_t i_func,
    input  wire cpu_core_pkg::byte_t       i_a,
    input  wire cpu_core_pkg::byte_t       i_b,
    input  wire logic                      i_carry,
    output cpu_core_pkg::byte_t            o_result,
    output logic                           o_carry
);
    import cpu_core_pkg::*;

    always_comb begin
        o_result = i_a;
        o_carry  = i_carry;
        unique case (i_func)
            LF_AND:  o_result = i_a & i_b;
            LF_OR:   o_result = i_a | i_b;
            LF_XOR:  o_result = i_a ^ i_b;
            LF_CLR:  o_result = '0;
            LF_CPL:  o_result = ~i_a;
            LF_RL:   o_result = {i_a[6:0], i_a[7]};
            LF_RLC: begin
                o_result = {i_a[6:0], i_carry};
                o_carry  = i_a[7];
            end
            LF_RR:   o_result = {i_a[0], i_a[7:1]};
            LF_RRC: begin
                o_result = {i_carry, i_a[7:1]};
                o_carry  = i_a[0];
            end
            LF_SWAP: o_result = {i_a[3:0], i_a[7:4]};
            default: o_result = i_a;
        endcase
    end
endmodule : byte_logic_unit

// ---- hdl/iram_store.sv ----
// internal data store: register banks, bit area, scratch bytes and stack
`timescale 1ns/100ps
module iram_store (
    input  wire logic                i_clk,
    input  wire logic                i_wr_en,
    input  wire cpu_core_pkg::byte_t i_wr_addr,
    input  wire cpu_core_pkg::byte_t i_wr_data,
    input  wire cpu_core_pkg::byte_t i_rd_addr_a,
    input  wire cpu_core_pkg::byte_t i_rd_addr_b,
    output cpu_core_pkg::byte_t      o_rd_data_a,
    output cpu_core_pkg::byte_t      o_rd_data_b
);
    import cpu_core_pkg::*;

    // not reset: contents are undefined until software writes them
    byte_t mem [IRAM_DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    // reads are combinational so a pointer and its target resolve in one cycle
    assign o_rd_data_a = mem[i_rd_addr_a];
    assign o_rd_data_b = mem[i_rd_addr_b];
endmodule : iram_store

// ---- hdl/cpu_logic_branch_exec.sv ----
// core sequencer: fetch, operand addressing, logic ops, branches and stack
`timescale 1ns/100ps
module cpu_logic_branch_exec (
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    input  wire cpu_core_pkg::byte_t i_code_data,
    output cpu_core_pkg::word_t      o_code_addr,
    output cpu_core_pkg::cpu_view_t  o_status,
    output logic                     o_retire
);
    import cpu_core_pkg::*;

    core_state_t state_q;
    core_state_t state_d;
    dec_t        dec;
    logic_func_t lu_func;
    byte_t       op;
    byte_t       arg1;
    byte_t       arg2;
    byte_t       rd_a;
    byte_t       rd_b;
    byte_t       addr_a;
    byte_t       addr_b;
    byte_t       opnd;
    byte_t       lu_a;
    byte_t       lu_b;
    byte_t       lu_res;
    byte_t       st_data;
    byte_t       cmp_lhs;
    byte_t       cmp_rhs;
    byte_t       dec_val;
    byte_t       bit_val;
    byte_t       ram_waddr;
    byte_t       ram_wdata;
    word_t       pc_next;
    word_t       abs_target;
    logic        lu_carry;
    logic        last;
    logic        is_pop;
    logic        is_call;
    logic        push_lo;
    logic        dir_sfr;
    logic        st_en;
    logic        ram_we;

    function automatic dec_t decode(input byte_t code);
        dec_t d;
        d.cls = CL_NOP;
        d.len = LEN_ONE;
        d.cyc = CYC_ONE;
        if (code[7:4] inside {OP_ORL_HI, OP_ANL_HI, OP_XRL_HI} && (|code[3:1])) begin
            d.cls = CL_LOGIC;
            if (code[3:1] == LN_IND) begin
                d.cyc = CYC_TWO;
            end else if (!code[3] && code[3:0] inside {LN_IMM, LN_DIR}) begin
                d.len = LEN_TWO;
                d.cyc = CYC_TWO;
            end else if (code[3:1] == LN_TO_DIR) begin
                d.len = code[0] ? LEN_THREE : LEN_TWO;
                d.cyc = CYC_THREE;
            end
        end else if (code[4:0] == OP_ABSOLUTE_JUMP_OP_LO) begin
            d.cls = CL_ABSOLUTE_JUMP_OP;
            d.len = LEN_TWO;
            d.cyc = CYC_THREE;
        end else if (code[4:0] == OP_ABSOLUTE_CALL_OP_LO) begin
            d.cls = CL_ABSOLUTE_CALL_OP;
            d.len = LEN_TWO;
            d.cyc = CYC_FOUR;
        end else if (code == OP_LONG_JUMP_OP || code == OP_LONG_CALL_OP) begin
            d.cls = (code == OP_LONG_JUMP_OP) ? CL_LONG_JUMP_OP : CL_LONG_CALL_OP;
            d.len = LEN_THREE;
            d.cyc = CYC_FOUR;
        end else if (code == OP_RET || code == OP_INTERRUPT_RETURN_OP) begin
            d.cls = (code == OP_RET) ? CL_RET : CL_INTERRUPT_RETURN_OP;
            d.cyc = CYC_FOUR;
        end else if (code inside {OP_CLR_A, OP_CPL_A, OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SWAP})
        begin
            d.cls = CL_ACC;
        end else if (code == OP_SHORT_JUMP_OP) begin
            d.cls = CL_SHORT_JUMP_OP;
            d.len = LEN_TWO;
            d.cyc = CYC_THREE;
        end else if (code == OP_JMP_IDX) begin
            d.cls = CL_JMPIDX;
            d.cyc = CYC_FIVE;
        end else if (code == OP_JZ || code == OP_JNZ) begin
            d.cls = (code == OP_JZ) ? CL_JZ : CL_JNZ;
            d.len = LEN_TWO;
            d.cyc = CYC_FOUR;
        end else if (code[7:4] == OP_COMPARE_JUMP_NE_OP_HI && code[3:0] >= LN_IMM) begin
            d.cls = CL_COMPARE_JUMP_NE_OP;
            d.len = LEN_THREE;
            d.cyc = (code[3:0] == LN_DIR || code[3:1] == LN_IND) ? CYC_FIVE : CYC_FOUR;
        end else if (code[7:4] == OP_DECREMENT_JUMP_NZ_OP_HI && (code[3] || code[3:0] == LN_DIR)) begin
            d.cls = CL_DECREMENT_JUMP_NZ_OP;
            d.len = code[3] ? LEN_TWO : LEN_THREE;
            d.cyc = code[3] ? CYC_FOUR : CYC_FIVE;
        end else if (code == OP_MOVC) begin
            d.cls = CL_MOVC;
            d.cyc = CYC_MOVC;
        end else if (code == OP_CLR_BIT || code == OP_SETB_BIT) begin
            d.cls = CL_BIT;
            d.len = LEN_TWO;
            d.cyc = CYC_BIT;
        end
        return d;
    endfunction : decode

    function automatic byte_t reg_addr(input byte_t psw, input logic [2:0] idx);
        return {3'h0, psw[PSW_RS_HI:PSW_RS_LO], idx};
    endfunction : reg_addr

    // bit number to its holding byte
    function automatic byte_t bit_byte(input byte_t bnum);
        return bnum[7] ? {bnum[7:3], 3'h0} : BIT_AREA_BASE + {4'h0, bnum[6:3]};
    endfunction : bit_byte

    function automatic word_t rel_target(input word_t base, input byte_t off);
        return base + {{8{off[7]}}, off};
    endfunction : rel_target

    function automatic word_t idx_addr(input core_state_t st);
        return st.data_pointer + {8'h00, st.acc};
    endfunction : idx_addr

    // parity flag is derived from acc; a psw store writes bit 0 but that bit is never read
    function automatic byte_t psw_view(input core_state_t st);
        byte_t v;
        v = st.psw;
        v[PSW_P] = ^st.acc;
        return v;
    endfunction : psw_view

    // unmapped special registers read as zero and ignore writes
    function automatic byte_t sfr_read(input core_state_t st, input byte_t a);
        byte_t v;
        v = '0;
        case (a)
            SFR_ACC: v = st.acc;
            SFR_PSW: v = psw_view(st);
            SFR_SP:  v = st.sp;
            SFR_DPL: v = st.data_pointer[7:0];
            SFR_DPH: v = st.data_pointer[15:8];
            default: v = '0;
        endcase
        return v;
    endfunction : sfr_read

    // operand bytes: the byte on the code port is used in the cycle it arrives
    assign op   = (state_q.cyc == CYC_ZERO) ? i_code_data : state_q.op;
    assign arg1 = (state_q.cyc == CYC_ONE) ? i_code_data : state_q.arg1;
    assign arg2 = (state_q.cyc == CYC_TWO) ? i_code_data : state_q.arg2;
    assign dec  = decode(op);
    assign last = (state_q.cyc + CYC_ONE) == dec.cyc;
    assign pc_next    = state_q.pc + {14'h0000, dec.len};
    assign abs_target = {pc_next[15:11], op[7:5], arg1};
    assign is_pop  = (dec.cls == CL_RET) || (dec.cls == CL_INTERRUPT_RETURN_OP);
    assign is_call = (dec.cls == CL_ABSOLUTE_CALL_OP) || (dec.cls == CL_LONG_CALL_OP);
    assign push_lo = is_call && ((state_q.cyc + CYC_TWO) == dec.cyc);

    // decided from registered state only, so the code port has no loop through decode
    // program memory read at the indexed address
    assign o_code_addr = (state_q.cyc == CYC_ONE && state_q.op == OP_MOVC)
                       ? idx_addr(state_q) : state_q.pc + {13'h0000, state_q.cyc};

    // pointer from working register 0 or 1, or sp minus one on a return
    assign addr_b = is_pop ? state_q.sp - SP_STEP : reg_addr(state_q.psw, {2'h0, op[0]});

    always_comb begin
        if (is_pop) begin
            addr_a = state_q.sp;
        end else if (dec.cls == CL_BIT) begin
            addr_a = bit_byte(arg1);
        end else if (op[3]) begin
            addr_a = reg_addr(state_q.psw, op[2:0]);
        end else if (op[3:1] == LN_IND) begin
            addr_a = rd_b;
        end else begin
            addr_a = arg1;
        end
    end

    // upper direct space reaches special registers
    assign dir_sfr = !is_pop && !op[3] && (op[3:1] != LN_IND) && addr_a[7];
    assign opnd    = dir_sfr ? sfr_read(state_q, addr_a) : rd_a;

    always_comb begin
        lu_func = LF_AND;
        lu_a    = state_q.acc;
        lu_b    = opnd;
        if (dec.cls == CL_LOGIC) begin
            unique case (op[7:4])
                OP_ORL_HI: lu_func = LF_OR;
                OP_XRL_HI: lu_func = LF_XOR;
                default:   lu_func = LF_AND;
            endcase
            if (op[3:1] == LN_TO_DIR) begin
                lu_a = opnd;
                lu_b = op[0] ? arg2 : state_q.acc;
            end else if (op[3:0] == LN_IMM) begin
                lu_b = arg1;
            end
        end else if (dec.cls == CL_ACC) begin
            unique case (op)
                OP_CLR_A: lu_func = LF_CLR;
                OP_CPL_A: lu_func = LF_CPL;
                OP_RL:    lu_func = LF_RL;
                OP_RLC:   lu_func = LF_RLC;
                OP_RR:    lu_func = LF_RR;
                OP_RRC:   lu_func = LF_RRC;
                default:  lu_func = LF_SWAP;
            endcase
        end
    end

    byte_logic_unit u_logic (
        .i_func   (lu_func),
        .i_a      (lu_a),
        .i_b      (lu_b),
        .i_carry  (state_q.psw[PSW_CY]),
        .o_result (lu_res),
        .o_carry  (lu_carry)
    );

    assign cmp_lhs = (op[3:0] == LN_IMM || op[3:0] == LN_DIR) ? state_q.acc : opnd;
    assign cmp_rhs = (op[3:0] == LN_DIR) ? opnd : arg1;
    assign dec_val = opnd - SP_STEP;
    always_comb begin
        bit_val = opnd;
        bit_val[arg1[2:0]] = (op == OP_SETB_BIT);
    end

    always_comb begin
        state_d   = state_q;
        st_en     = 1'b0;
        st_data   = '0;
        ram_we    = 1'b0;
        ram_waddr = '0;
        ram_wdata = '0;
        state_d.cyc = last ? CYC_ZERO : state_q.cyc + CYC_ONE;
        unique case (state_q.cyc)
            CYC_ZERO: state_d.op = i_code_data;
            CYC_ONE:  state_d.arg1 = i_code_data;
            CYC_TWO:  state_d.arg2 = i_code_data;
            default:  state_d.op = state_q.op;
        endcase
        if (push_lo) begin
            ram_we    = 1'b1;
            ram_waddr = state_q.sp + SP_STEP;
            ram_wdata = pc_next[7:0];
        end
        if (last) begin
            state_d.pc = pc_next;
            unique case (dec.cls)
                CL_NOP: state_d.pc = pc_next;
                CL_LOGIC: begin
                    if (op[3:1] == LN_TO_DIR) begin
                        st_en   = 1'b1;
                        st_data = lu_res;
                    end else begin
                        state_d.acc = lu_res;
                    end
                end
                CL_ACC: begin
                    state_d.acc = lu_res;
                    state_d.psw[PSW_CY] = lu_carry;
                end
                CL_ABSOLUTE_JUMP_OP: state_d.pc = abs_target;
                CL_LONG_JUMP_OP: state_d.pc = {arg1, arg2};
                CL_ABSOLUTE_CALL_OP, CL_LONG_CALL_OP: begin
                    ram_we     = 1'b1;
                    ram_waddr  = state_q.sp + SP_PAIR;
                    ram_wdata  = pc_next[15:8];
                    state_d.sp = state_q.sp + SP_PAIR;
                    state_d.pc = (dec.cls == CL_ABSOLUTE_CALL_OP) ? abs_target : {arg1, arg2};
                end
                CL_RET, CL_INTERRUPT_RETURN_OP: begin
                    state_d.pc = {rd_a, rd_b};
                    state_d.sp = state_q.sp - SP_PAIR;
                end
                CL_SHORT_JUMP_OP: state_d.pc = rel_target(pc_next, arg1);
                CL_JMPIDX: state_d.pc = idx_addr(state_q);
                CL_JZ: begin
                    if (state_q.acc == '0) begin
                        state_d.pc = rel_target(pc_next, arg1);
                    end
                end
                CL_JNZ: begin
                    if (state_q.acc != '0) begin
                        state_d.pc = rel_target(pc_next, arg1);
                    end
                end
                CL_COMPARE_JUMP_NE_OP: begin
                    state_d.psw[PSW_CY] = cmp_lhs < cmp_rhs;
                    if (cmp_lhs != cmp_rhs) begin
                        state_d.pc = rel_target(pc_next, arg2);
                    end
                end
                CL_DECREMENT_JUMP_NZ_OP: begin
                    st_en   = 1'b1;
                    st_data = dec_val;
                    if (dec_val != '0) begin
                        state_d.pc = rel_target(pc_next, op[3] ? arg1 : arg2);
                    end
                end
                CL_MOVC: state_d.acc = i_code_data;
                CL_BIT: begin
                    st_en   = 1'b1;
                    st_data = bit_val;
                end
            endcase
        end
        // store back to the operand location
        if (st_en) begin
            if (dir_sfr) begin
                case (addr_a)
                    SFR_ACC: state_d.acc = st_data;
                    SFR_PSW: state_d.psw = st_data;
                    SFR_SP:  state_d.sp = st_data;
                    SFR_DPL: state_d.data_pointer[7:0] = st_data;
                    SFR_DPH: state_d.data_pointer[15:8] = st_data;
                    default: state_d.acc = state_d.acc;
                endcase
            end else begin
                ram_we    = 1'b1;
                ram_waddr = addr_a;
                ram_wdata = st_data;
            end
        end
    end

    // banks and bit area live in the low ram bytes
    iram_store u_iram (
        .i_clk       (i_clk),
        .i_wr_en     (ram_we),
        .i_wr_addr   (ram_waddr),
        .i_wr_data   (ram_wdata),
        .i_rd_addr_a (addr_a),
        .i_rd_addr_b (addr_b),
        .o_rd_data_a (rd_a),
        .o_rd_data_b (rd_b)
    );

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= CORE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_retire = last;
    assign o_status = '{pc: state_q.pc, acc: state_q.acc, psw: psw_view(state_q),
                        sp: state_q.sp, data_pointer: state_q.data_pointer};
endmodule : cpu_logic_branch_exec

// ---- verification/cpu_logic_branch_exec_chk.sv ----
// timing and result checks on the core's code port and visible state
`timescale 1ns/100ps
module cpu_logic_branch_exec_chk
    import cpu_core_pkg::*;
(
    input wire logic                    i_clk,
    input wire logic                    i_sys_rst,
    input wire cpu_core_pkg::byte_t     i_code_data,
    input wire cpu_core_pkg::word_t     o_code_addr,
    input wire cpu_core_pkg::cpu_view_t o_status,
    input wire logic                    o_retire
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire word_t pc = o_status.pc;
    wire byte_t ac = o_status.acc;
    wire byte_t sp = o_status.sp;
    wire byte_t d  = i_code_data;
    wire logic  r  = o_retire;
    // only the first cycle of an instruction presents the pc itself, or a movc second cycle whose dp plus acc equals the pc
    wire logic  c0 = o_code_addr == pc;
    wire word_t rt = pc + 16'h0002 + {{8{d[7]}}, d};
    a_or_imm: assert property (c0 && d == 8'h44 |->
        !r ##1 r ##1 ac == ($past(ac, 2) | $past(d))) else $error("or imm");
    a_short_jump: assert property (c0 && d == OP_SHORT_JUMP_OP |->
        !r [*2] ##1 r ##1 pc == $past(rt, 2)) else $error("short jump");
    a_long_jump: assert property (c0 && d == OP_LONG_JUMP_OP |->
        !r [*3] ##1 r ##1 pc == {$past(d, 3), $past(d, 2)}) else $error("long jump");
    a_jnz_taken: assert property (c0 && d == OP_JNZ && ac != 8'h00 |->
        !r [*3] ##1 r ##1 pc == $past(rt, 3)) else $error("jnz");
    a_indexed_jump: assert property (c0 && d == OP_JMP_IDX |->
        !r [*4] ##1 r ##1 pc == o_status.data_pointer + {8'h00, ac}) else $error("indexed jump");
    a_call_push: assert property (c0 && d == OP_LONG_CALL_OP |->
        !r [*3] ##1 r ##1 sp == $past(sp) + SP_PAIR) else $error("call");
    a_ret_pop: assert property (c0 && d == OP_RET |->
        !r [*3] ##1 r ##1 sp == $past(sp) - SP_PAIR) else $error("return");
    a_compare_carry: assert property (c0 && d == 8'hB4 |->
        !r [*3] ##1 r ##1 o_status.psw[PSW_CY] == ($past(ac) < $past(d, 3))) else $error("cy");
endmodule : cpu_logic_branch_exec_chk
bind cpu_logic_branch_exec cpu_logic_branch_exec_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_code_data(i_code_data), .o_code_addr(o_code_addr), .o_status(o_status), .o_retire(o_retire));

// ---- verification/cpu_logic_branch_exec_tb.sv ----
// bench: runs a small program from a code table and checks timing and state
`timescale 1ns/100ps
module cpu_logic_branch_exec_tb;
    import cpu_core_pkg::*;
    logic      i_clk, i_sys_rst, o_retire;
    byte_t     rom [256];
    word_t     o_code_addr;
    cpu_view_t o_status;
    int        bad_count, checks_done;
    cpu_logic_branch_exec u_cpu_logic_branch_exec (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_code_data(rom[o_code_addr[7:0]]), .o_code_addr(o_code_addr), .o_status(o_status),
        .o_retire(o_retire));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic cmp(input word_t got, input word_t exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask : cmp
    // e packs cycle count, pc and accumulator expected after one instruction
    task automatic step(input logic [27:0] e);
        word_t n;
        n = 16'h0001;
        while (o_retire !== 1'b1 && n < 16'h0009) begin
            @(posedge i_clk) #1;
            n++;
        end
        // a hung instruction is counted as a mismatch by the cycle check just below; the run still ends in one place
        cmp(n, {12'h000, e[27:24]});
        if (n == 16'h0009) return;
        @(posedge i_clk) #1;
        cmp(o_status.pc, e[23:8]);
        cmp({8'h00, o_status.acc}, {8'h00, e[7:0]});
    endtask : step
    task automatic t_logic;
        step(28'h1_0001_00);
        step(28'h2_0003_5A);
        step(28'h2_0005_0A);
        step(28'h2_0007_F5);
        step(28'h1_0008_EB);
        step(28'h1_0009_BE);
        step(28'h1_000A_41);
        step(28'h1_000B_A0);
    endtask : t_logic
    task automatic t_flow;
        step(28'h4_000D_A0);
        step(28'h4_0010_A0);
        step(28'h4_0013_A0);
        cmp({15'h0000, o_status.psw[PSW_CY]}, 16'h0000);
        step(28'h4_0016_A0);
        cmp({15'h0000, o_status.psw[PSW_CY]}, 16'h0001);
        step(28'h4_0019_A0);
        step(28'h4_0020_A0);
        cmp({8'h00, o_status.sp}, 16'h0009);
        step(28'h1_0021_41);
        step(28'h1_0022_A0);
        step(28'h4_001C_A0);
        cmp({8'h00, o_status.sp}, 16'h0007);
        step(28'h3_001F_A0);
        cmp(o_status.data_pointer, 16'h0012);
        step(28'h5_00B2_A0);
        step(28'h2_00B3_93);
        step(28'h3_00B6_93);
        step(28'h3_00B9_93);
        step(28'h3_00BC_93);
        step(28'h1_00BD_02);
        step(28'h2_00BE_00);
        step(28'h4_00BE_00);
        step(28'h4_00C0_00);
        step(28'h3_00C2_02);
        step(28'h3_00C6_02);
        step(28'h3_00C6_02);
    endtask : t_flow
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        byte_t p[$], q[$];
        p = {8'hE4, 8'h44, 8'h5A, 8'h54, 8'h0F, 8'h64, 8'hFF, 8'h23, 8'hC4, 8'hF4, 8'h03,
             8'h60, 8'h02, 8'h70, 8'h01, 8'h00, 8'hB4, 8'hA0, 8'h02, 8'hB4, 8'hA1, 8'h00,
             8'h02, 8'h00, 8'h19, 8'h12, 8'h00, 8'h20, 8'h43, 8'h82, 8'h12, 8'h73,
             8'h33, 8'h13, 8'h22};
        foreach (rom[i]) rom[i] = (i < p.size()) ? p[i] : 8'h00;
        // indexed read, register, indirect, decrement loop, bit set into acc, absolute jump
        q = {8'h93, 8'h53, 8'h01, 8'h00, 8'h53, 8'h00, 8'h00, 8'h43, 8'h00, 8'h02, 8'h58,
             8'h67, 8'hD8, 8'hFE, 8'hD2, 8'hE1, 8'h01, 8'hC6, 8'h00, 8'h00, 8'h80, 8'hFE};
        foreach (q[i]) rom[8'hB2 + i] = q[i];
        bad_count = 0;
        checks_done = 0;
        i_sys_rst = 1'b1;
        repeat (5) @(posedge i_clk);
        #1 i_sys_rst = 1'b0;
        t_logic();
        t_flow();
        give_verdict();
    end
endmodule : cpu_logic_branch_exec_tb
